// >>> ee_model.sv
// EEPROM responder that feeds the control module its load image.
// Assumes one word request at a time on core_clk.
`timescale 1ns/1ps
module ee_model (
    input  wire logic        core_clk,
    input  wire logic        eeReq,
    input  wire logic [7:0]  eeAddr,
    output logic             eeAck,
    output logic      [31:0] eeData
);
    logic [1:0] gap = 2'h0;
    function automatic logic [31:0] img(input logic [7:0] a);
        logic [7:0] w;
        w = a - 8'h06;
        case (a)
            8'h00: img = 32'h0200_7755;
            8'h01: img = 32'h40ff_00ff;
            8'h02: img = 32'h5678_1234;
            8'h03: img = 32'h0201_0100;
            8'h04: img = 32'h0000_0103;
            8'h05: img = 32'h0000_0008;
            default: img = {w + 8'h30, w + 8'h20, w + 8'h10,
                            (w[3:0] == 4'h0) ? 8'h06 : w};
        endcase
    endfunction
    initial eeAck = 1'h0;
    initial eeData = 32'h0;
    // Answers on every other cycle; between answers the data lines toggle.
    always @(posedge core_clk) begin
        gap <= gap + 2'h1;
        eeAck <= eeReq && !eeAck && gap[0];
        eeData <= (eeReq && !eeAck && gap[0]) ? img(eeAddr) : ~eeData;
    end
endmodule

// >>> string_port_if.sv
// Write and read port of the string descriptor store.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface string_port_if #(parameter int AW = 7, parameter int DW = 32);
    logic          wrEn;
    logic [AW-1:0] wrAddr;
    logic [DW-1:0] wrData;
    logic [AW-1:0] rdAddr;
    logic [DW-1:0] rdData;
    modport store (input wrEn, wrAddr, wrData, rdAddr, output rdData);
    modport user  (output wrEn, wrAddr, wrData, rdAddr, input rdData);
endinterface

// >>> string_store.sv
// String descriptor store: a word array with one write and one read port.
// Assumes it is filled by the control module after every reset with an EEPROM present.
`timescale 1ns/1ps
module string_store #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 32
) (
    input wire logic     core_clk,
    string_port_if.store port
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Words are written by the loader and read without latency.
    always_ff @(posedge core_clk) begin
        if (port.wrEn) begin
            mem[port.wrAddr] <= port.wrData;
        end
    end

    assign port.rdData = mem[port.rdAddr];
endmodule

// >>> tb.sv
// Self-checking bench for the USB control module.
// Assumes the EEPROM responder model serves the load after reset.
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'h0;
    logic        srst = 1'h1;
    logic [7:0]  avsAddress = 8'h0;
    logic        avsRead = 1'h0;
    logic        avsWrite = 1'h0;
    logic [31:0] avsWriteData = 32'h0;
    logic [19:0] ev = 20'h0;
    logic        intStsWrite = 1'h0;
    logic [31:0] intStsWriteData = 32'h0;
    logic        intToken = 1'h0;
    logic        reqValid = 1'h0;
    logic        reqVendor = 1'h0;
    logic [15:0] reqPointer = 16'h0;
    logic [15:0] reqLength = 16'h0;
    logic        txReady = 1'h1;
    logic        eePresent = 1'h1;
    logic [31:0] avsReadData, intData, eeData;
    logic [7:0]  pollInterval, txData, eeAddr;
    logic        avsWaitrequest, intRespValid, intNak, reqReady, txValid;
    logic        txLast, ctlDone, ctlStall, eeReq, eeAck;
    int          bad_count = 0;
    int          check_count = 0;
    int          nakSeen = 0;
    logic [7:0]  exp[$];
    always #12.5 core_clk = ~core_clk;
    usb_control_interrupt_endpoint uut (.core_clk(core_clk), .srst(srst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
        .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
        .macResetTimeoutEvent(ev[19]), .rxFifoHasFrame(ev[18]),
        .transmitStoppedEvent(ev[17]), .receiveStoppedEvent(ev[16]),
        .lineInterfaceEvent(ev[15]), .transmitErrorFlag(ev[14]),
        .txFifoUnderrunFlag(ev[13]), .txFifoOverrunFlag(ev[12]),
        .rxDroppedFrameEvent(ev[11]), .gpioEvent(ev[10:0]),
        .intStsWrite(intStsWrite), .intStsWriteData(intStsWriteData),
        .intToken(intToken), .intRespValid(intRespValid), .intNak(intNak),
        .intData(intData), .pollInterval(pollInterval),
        .reqValid(reqValid), .reqVendor(reqVendor), .reqPointer(reqPointer),
        .reqLength(reqLength), .reqReady(reqReady), .txValid(txValid),
        .txData(txData), .txLast(txLast), .txReady(txReady),
        .ctlDone(ctlDone), .ctlStall(ctlStall), .eepromPresent(eePresent),
        .eeReq(eeReq), .eeAddr(eeAddr), .eeAck(eeAck), .eeData(eeData));
    ee_model eem (.core_clk(core_clk), .eeReq(eeReq && eePresent),
        .eeAddr(eeAddr), .eeAck(eeAck), .eeData(eeData));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic av(logic wr, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] q);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge core_clk);
        while (avsWaitrequest !== 1'h0);
        q = avsReadData;
        avsRead <= 1'h0;
        avsWrite <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic poll(logic nak, logic [31:0] d);
        intToken <= 1'h1;
        @(posedge core_clk);
        intToken <= 1'h0;
        @(posedge core_clk);
        chk("intRespValid", 1, intRespValid);
        chk("intNak", nak, intNak);
        if (!nak) chk("intData", d, intData);
        nakSeen += nak;
    endtask
    // Sends one control request and checks the byte stream against exp.
    task automatic req(logic v, logic [15:0] p, logic [15:0] len, logic st);
        int k;
        k = 0;
        while (reqReady !== 1'h1) @(posedge core_clk);
        reqVendor <= v;
        reqPointer <= p;
        reqLength <= len;
        reqValid <= 1'h1;
        @(posedge core_clk);
        reqValid <= 1'h0;
        while (ctlDone !== 1'h1 && ctlStall !== 1'h1) begin
            @(posedge core_clk);
            if (txValid === 1'h1 && txReady === 1'h1) begin
                chk("txData", exp[k], txData);
                chk("txLast", k == exp.size() - 1, txLast);
                k++;
            end
            txReady <= ~txReady;
        end
        chk("ctlStall", st, ctlStall);
        chk("byteCount", exp.size(), k);
        @(posedge core_clk);
    endtask
    function automatic logic [7:0] sb(int w, int b);
        logic [31:0] x;
        x = {8'(w + 8'h30), 8'(w + 8'h20), 8'(w + 8'h10),
             (w % 16 == 0) ? 8'h06 : 8'(w)};
        return x[8*b +: 8];
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        logic [31:0] q;
        repeat (20) @(posedge core_clk);
        srst <= 1'h0;
        while (reqReady !== 1'h1) @(posedge core_clk);
        chk("pollInterval", 8'h08, pollInterval);
        av(0, usb_ctl_pkg::REG_STATUS, 0, q);
        chk("loaded", 1, q[0]);
        av(0, 8'h40, 0, q);
        chk("unmapped", 0, q);
        poll(1, 0);
        for (int i = 0; i < 20; i++) begin
            ev[i] <= 1'h1;
            @(posedge core_clk);
            poll(0, 32'h1 << i);
            ev[i] <= 1'h0;
            intStsWrite <= 1'h1;
            intStsWriteData <= 32'h1 << i;
            @(posedge core_clk);
            intStsWrite <= 1'h0;
            @(posedge core_clk);
            poll(1, 0);
        end
        ev[0] <= 1'h1;
        @(posedge core_clk);
        ev[0] <= 1'h0;
        av(1, usb_ctl_pkg::REG_CTRL, 0, q);
        poll(1, 0);
        av(1, usb_ctl_pkg::REG_CTRL, 1, q);
        poll(0, 1);
        exp = '{8'h12, 8'h01, 8'h00, 8'h02, 8'hff, 8'h00, 8'hff, 8'h40,
                8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h01, 8'h01, 8'h02,
                8'h03, 8'h01};
        req(0, 16'h0100, 16'h00ff, 0);
        exp = exp[0:7];
        req(0, 16'h0100, 16'h0008, 0);
        exp = {};
        req(0, 16'h0100, 16'h0000, 0);
        for (int b = 0; b < 6; b++) exp.push_back(sb(16 + b / 4, b % 4));
        req(0, 16'h0301, 16'h00ff, 0);
        exp = {};
        req(0, 16'h0306, 16'h00ff, 1);
        for (int b = 0; b < 4; b++) exp.push_back(8'(nakSeen >> 8 * b));
        req(1, 16'h0001, 16'h00ff, 0);
        av(0, usb_ctl_pkg::REG_INT_COUNT, 0, q);
        chk("intCount", 21, q);
        av(0, usb_ctl_pkg::REG_DESC_COUNT, 0, q);
        chk("descCount", 5, q);
        eePresent <= 1'h0;
        srst <= 1'h1;
        repeat (2) @(posedge core_clk);
        srst <= 1'h0;
        while (reqReady !== 1'h1) @(posedge core_clk);
        chk("pollInterval", 8'h04, pollInterval);
        exp = '{8'h12, 8'h01, 8'h00, 8'h02, 8'hff, 8'h00, 8'hff, 8'h40,
                8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h01, 8'h00, 8'h00,
                8'h00, 8'h01};
        req(0, 16'h0100, 16'h00ff, 0);
        give_verdict();
    end
endmodule

// >>> usb_control_interrupt_endpoint.sv
// USB control module: interrupt endpoint, descriptor and vendor replies.
// Assumes the device core, EEPROM controller and status logic share
// core_clk, so their signals need no synchroniser.
//
// How it works
// - Each interrupt poll after load returns current status packet.
// - Packet fields: reserved, events, frame waiting, GPIO.
// - Nothing pending means the poll is NACKed.
// - Polling interval defaults to 04h, set only by EEPROM load.
// - Status write clears pending bits; events win.
// - Completes Get Descriptor and vendor requests.
// - Counts statistics and holds descriptor fields.
// - String descriptors live in 128 by 32 store.
// - String store refilled from EEPROM after reset when an EEPROM is present.
// - String index zero to five picks descriptor.
// - Request pointer selects descriptor type and index.
// - Device length and type forced to 12h, 01h.
// - Device descriptor reply is 18 bytes, or fewer if the request length is shorter.
// - Specification release defaults to 0200h.
// - Endpoint zero packet size defaults to 40h.
// - String index fields default 00h, EEPROM replaceable.
// - Configuration count defaults to 01h.
// - Release number is silicon release then 00h.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module usb_control_interrupt_endpoint #(
    parameter logic [15:0] VENDOR_ID   = 16'h1234,
    parameter logic [15:0] PRODUCT_ID  = 16'h5678,
    parameter logic [7:0]  SILICON_REL = 8'h01,
    parameter int          STRING_WORDS = 128
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic      [31:0] avsReadData,
    output logic             avsWaitrequest,
    input  wire logic        macResetTimeoutEvent,
    input  wire logic        rxFifoHasFrame,
    input  wire logic        transmitStoppedEvent,
    input  wire logic        receiveStoppedEvent,
    input  wire logic        lineInterfaceEvent,
    input  wire logic        transmitErrorFlag,
    input  wire logic        txFifoUnderrunFlag,
    input  wire logic        txFifoOverrunFlag,
    input  wire logic        rxDroppedFrameEvent,
    input  wire logic [10:0] gpioEvent,
    input  wire logic        intStsWrite,
    input  wire logic [31:0] intStsWriteData,
    input  wire logic        intToken,
    output logic             intRespValid,
    output logic             intNak,
    output logic      [31:0] intData,
    output logic      [7:0]  pollInterval,
    input  wire logic        reqValid,
    input  wire logic        reqVendor,
    input  wire logic [15:0] reqPointer,
    input  wire logic [15:0] reqLength,
    output logic             reqReady,
    output logic             txValid,
    output logic      [7:0]  txData,
    output logic             txLast,
    input  wire logic        txReady,
    output logic             ctlDone,
    output logic             ctlStall,
    input  wire logic        eepromPresent,
    output logic             eeReq,
    output logic      [7:0]  eeAddr,
    input  wire logic        eeAck,
    input  wire logic [31:0] eeData
);
    localparam int RAW = $clog2(STRING_WORDS);

    string_port_if #(.AW(RAW), .DW(32)) strPort ();
    string_store #(.DEPTH(STRING_WORDS), .WIDTH(32)) u_store (
        .core_clk (core_clk),
        .port     (strPort.store)
    );

    usb_ctl_pkg::load_state_t loadState;
    usb_ctl_pkg::resp_state_t state;
    usb_ctl_pkg::kind_t       respKind;
    logic [31:0] devDesc [5];
    logic [19:0] pendingSticky;
    logic [31:0] packet;
    logic        loadDone;
    logic        intEnable;
    logic [31:0] intCount;
    logic [31:0] nakCount;
    logic [31:0] descCount;
    logic [RAW-1:0] respBase;
    logic [15:0] respLen;
    logic [15:0] byteCnt;
    logic [1:0]  statSel;
    logic [31:0] curWord;
    logic [7:0]  curByte;
    logic        accept;
    logic        busAck;
    logic [15:0] strLen;
    logic [7:0]  descType;
    logic [7:0]  descIndex;

    // EEPROM fill of descriptor words, polling interval and strings.
    assign eeReq = (loadState == usb_ctl_pkg::LD_REQ);
    assign loadDone = (loadState == usb_ctl_pkg::LD_DONE);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            loadState <= usb_ctl_pkg::LD_REQ;
            eeAddr    <= 8'h00;
        end else if (eeReq && !eepromPresent) begin
            loadState <= usb_ctl_pkg::LD_DONE;
        end else if (eeReq && eeAck) begin
            eeAddr <= eeAddr + 8'h01;
            if (eeAddr == usb_ctl_pkg::EE_LAST_WORD) begin
                loadState <= usb_ctl_pkg::LD_DONE;
            end
        end
    end

    assign strPort.wrEn   = eeReq && eeAck &&
                            eeAddr >= usb_ctl_pkg::EE_STRING_WORD;
    assign strPort.wrAddr = RAW'(eeAddr - usb_ctl_pkg::EE_STRING_WORD);
    assign strPort.wrData = eeData;

    // Device descriptor defaults, replaced word by word from the EEPROM.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            devDesc[0] <= {usb_ctl_pkg::DEF_BCD_USB, 16'h0000};
            devDesc[1] <= {usb_ctl_pkg::DEF_MAX_PACKET,
                           usb_ctl_pkg::DEF_PROTOCOL,
                           usb_ctl_pkg::DEF_SUBCLASS,
                           usb_ctl_pkg::DEF_CLASS};
            devDesc[2] <= {PRODUCT_ID, VENDOR_ID};
            devDesc[3] <= {usb_ctl_pkg::DEF_STRING_INDEX,
                           usb_ctl_pkg::DEF_STRING_INDEX,
                           SILICON_REL, usb_ctl_pkg::DEF_RELEASE_LOW};
            devDesc[4] <= {16'h0000, usb_ctl_pkg::DEF_NUM_CONFIGS,
                           usb_ctl_pkg::DEF_STRING_INDEX};
            pollInterval <= usb_ctl_pkg::DEF_POLL_INTERVAL;
        end else if (eeReq && eeAck) begin
            if (eeAddr < usb_ctl_pkg::EE_DEV_WORDS) begin
                devDesc[eeAddr[2:0]] <= eeData;
            end
            if (eeAddr == usb_ctl_pkg::EE_POLL_WORD) begin
                pollInterval <= eeData[7:0];
            end
        end
    end

    // Pending status: events set sticky bits, status writes clear them.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pendingSticky <= 20'h00000;
        end else begin
            pendingSticky <= (pendingSticky &
                              ~intStsWriteData[19:0] &
                              {20{intStsWrite}} ^ pendingSticky &
                              {20{intStsWrite}} ^ pendingSticky) |
                             {macResetTimeoutEvent, 1'b0,
                              transmitStoppedEvent, receiveStoppedEvent,
                              lineInterfaceEvent, transmitErrorFlag,
                              txFifoUnderrunFlag, txFifoOverrunFlag,
                              rxDroppedFrameEvent, gpioEvent};
        end
    end

    always_comb begin
        packet = 32'h00000000;
        packet[usb_ctl_pkg::PKT_USED_BITS-1:0] = pendingSticky;
        packet[usb_ctl_pkg::PKT_FRAME_BIT] = rxFifoHasFrame;
    end

    // Interrupt endpoint: answer each poll after load with the packet or a NACK.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            intRespValid <= 1'b0;
            intNak       <= 1'b0;
            intData      <= 32'h00000000;
        end else begin
            intRespValid <= intToken && loadDone;
            if (intToken && loadDone) begin
                intNak  <= (packet == 32'h00000000) || !intEnable;
                intData <= packet;
            end
        end
    end

    // Statistics gathered for vendor requests and software.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            intCount  <= 32'h00000000;
            nakCount  <= 32'h00000000;
            descCount <= 32'h00000000;
        end else begin
            if (intRespValid && !intNak) begin
                intCount <= intCount + 32'h00000001;
            end
            if (intRespValid && intNak) begin
                nakCount <= nakCount + 32'h00000001;
            end
            if (accept && !reqVendor) begin
                descCount <= descCount + 32'h00000001;
            end
        end
    end

    // Request pointer: descriptor type in the high byte, index low.
    assign descType  = reqPointer[15:8];
    assign descIndex = reqPointer[7:0];
    assign reqReady = loadDone && (state == usb_ctl_pkg::ST_IDLE);
    assign accept   = reqValid && reqReady;

    // The first word of a string region holds its length byte.
    assign strPort.rdAddr = (state == usb_ctl_pkg::ST_IDLE) ?
                            RAW'({descIndex[2:0], 4'h0}) :
                            respBase + RAW'(byteCnt[15:2]);
    assign strLen = ({8'h00, strPort.rdData[7:0]} >
                     usb_ctl_pkg::STRING_MAX_BYTES) ?
                    usb_ctl_pkg::STRING_MAX_BYTES :
                    {8'h00, strPort.rdData[7:0]};

    always_comb begin
        case (respKind)
            usb_ctl_pkg::KIND_DEVICE: begin
                curWord = devDesc[byteCnt[4:2]];
                if (byteCnt[4:2] == 3'h0) begin
                    curWord[15:0] = {usb_ctl_pkg::DESC_TYPE_DEVICE,
                                     usb_ctl_pkg::DEV_LENGTH};
                end
            end
            usb_ctl_pkg::KIND_STRING: curWord = strPort.rdData;
            usb_ctl_pkg::KIND_STAT: begin
                case (statSel)
                    2'h0:    curWord = intCount;
                    2'h1:    curWord = nakCount;
                    default: curWord = descCount;
                endcase
            end
            default: curWord = 32'h00000000;
        endcase
    end
    assign curByte = curWord[{byteCnt[1:0], 3'h0} +: 8];

    // Control reply engine.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state    <= usb_ctl_pkg::ST_IDLE;
            respKind <= usb_ctl_pkg::KIND_DEVICE;
            respBase <= '0;
            respLen  <= 16'h0000;
            byteCnt  <= 16'h0000;
            statSel  <= 2'h0;
            txValid  <= 1'b0;
            txData   <= 8'h00;
            txLast   <= 1'b0;
            ctlDone  <= 1'b0;
            ctlStall <= 1'b0;
        end else begin
            ctlDone  <= 1'b0;
            ctlStall <= 1'b0;
            case (state)
                usb_ctl_pkg::ST_IDLE: begin
                    byteCnt <= 16'h0000;
                    if (accept && reqVendor) begin
                        if (descIndex <= usb_ctl_pkg::STAT_LAST) begin
                            state    <= usb_ctl_pkg::ST_SEND;
                            respKind <= usb_ctl_pkg::KIND_STAT;
                            statSel  <= descIndex[1:0];
                            respLen  <= (reqLength < usb_ctl_pkg::STAT_BYTES)
                                        ? reqLength
                                        : usb_ctl_pkg::STAT_BYTES;
                        end else begin
                            ctlStall <= 1'b1;
                        end
                    end else if (accept && descType ==
                                 usb_ctl_pkg::DESC_TYPE_DEVICE) begin
                        state    <= usb_ctl_pkg::ST_SEND;
                        respKind <= usb_ctl_pkg::KIND_DEVICE;
                        respLen  <= (reqLength < usb_ctl_pkg::DEV_BYTES) ?
                                    reqLength : usb_ctl_pkg::DEV_BYTES;
                    end else if (accept && descType ==
                                 usb_ctl_pkg::DESC_TYPE_STRING &&
                                 descIndex <=
                                 usb_ctl_pkg::STRING_LAST_INDEX) begin
                        state    <= usb_ctl_pkg::ST_SEND;
                        respKind <= usb_ctl_pkg::KIND_STRING;
                        respBase <= RAW'({descIndex[2:0], 4'h0});
                        respLen  <= (reqLength < strLen) ?
                                    reqLength : strLen;
                    end else if (accept) begin
                        ctlStall <= 1'b1;
                    end
                end
                usb_ctl_pkg::ST_SEND: begin
                    if (!txValid || txReady) begin
                        if (byteCnt < respLen) begin
                            txValid <= 1'b1;
                            txData  <= curByte;
                            txLast  <= (byteCnt + 16'h0001 == respLen);
                            byteCnt <= byteCnt + 16'h0001;
                        end else begin
                            txValid <= 1'b0;
                            txLast  <= 1'b0;
                            ctlDone <= 1'b1;
                            state   <= usb_ctl_pkg::ST_IDLE;
                        end
                    end
                end
                default: state <= usb_ctl_pkg::ST_IDLE;
            endcase
        end
    end

    // Avalon-MM slave: every access is answered one cycle after it starts.
    assign avsWaitrequest = (avsRead || avsWrite) && !busAck;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busAck      <= 1'b0;
            avsReadData <= 32'h00000000;
        end else begin
            busAck <= (avsRead || avsWrite) && !busAck;
            if (avsRead && !busAck) begin
                case (avsAddress)
                    usb_ctl_pkg::REG_CTRL:
                        avsReadData <= {31'h0, intEnable};
                    usb_ctl_pkg::REG_STATUS:
                        avsReadData <= {30'h0,
                                        state != usb_ctl_pkg::ST_IDLE,
                                        loadDone};
                    usb_ctl_pkg::REG_PACKET:     avsReadData <= packet;
                    usb_ctl_pkg::REG_INT_COUNT:  avsReadData <= intCount;
                    usb_ctl_pkg::REG_NAK_COUNT:  avsReadData <= nakCount;
                    usb_ctl_pkg::REG_DESC_COUNT: avsReadData <= descCount;
                    usb_ctl_pkg::REG_POLL:
                        avsReadData <= {24'h0, pollInterval};
                    default:                     avsReadData <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            intEnable <= usb_ctl_pkg::CTRL_RESET[0];
        end else if (avsWrite && busAck && avsByteEnable[0] &&
                     avsAddress == usb_ctl_pkg::REG_CTRL) begin
            intEnable <= avsWriteData[usb_ctl_pkg::CTRL_INT_ENABLE_BIT];
        end
    end

    a_nak_when_empty: assert property (@(posedge core_clk) disable iff (srst)
        intToken && loadDone && packet == 32'h0 |=> intRespValid && intNak)
        else $error("Empty poll was not NACKed.");
    a_packet_sent: assert property (@(posedge core_clk) disable iff (srst)
        intToken && loadDone && intEnable && packet != 32'h0
        |=> !intNak && intData == $past(packet))
        else $error("Poll did not return the status packet.");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (srst)
        intRespValid |-> intData[31:20] == 12'h000)
        else $error("Reserved packet bits are set.");
    a_clear_pending: assert property (@(posedge core_clk) disable iff (srst)
        intStsWrite && intStsWriteData[0] && !gpioEvent[0]
        |=> !pendingSticky[0])
        else $error("Status write did not clear a bit.");
    a_event_wins: assert property (@(posedge core_clk) disable iff (srst)
        gpioEvent[1] |=> pendingSticky[1])
        else $error("Event lost against a clear.");
    a_forced_header: assert property (@(posedge core_clk) disable iff (srst)
        accept && !reqVendor && descType == 8'h01 && reqLength > 16'h1
        |=> ##[1:40] txValid && txData == 8'h12 ##[1:40] txValid &&
        txData == 8'h01)
        else $error("Device header not forced.");
    a_device_length: assert property (@(posedge core_clk) disable iff (srst)
        accept && !reqVendor && descType == 8'h01
        |=> respLen <= 16'h0012 && respLen <= $past(reqLength))
        else $error("Device reply length wrong.");
    a_bad_string: assert property (@(posedge core_clk) disable iff (srst)
        accept && !reqVendor && descType == 8'h03 && descIndex > 8'h05
        |=> ctlStall)
        else $error("Unknown string index not stalled.");
    a_poll_static: assert property (@(posedge core_clk) disable iff (srst)
        loadDone && $past(loadDone) |-> $stable(pollInterval))
        else $error("Polling interval changed after load.");
    a_load_after_reset: assert property (@(posedge core_clk)
        $fell(srst) |-> eeReq)
        else $error("String fill did not start after reset.");
endmodule

// >>> usb_ctl_pkg.sv
// Constants, register map and state types for the USB control module.
// Assumes a 40 MHz core clock and a 32-bit Avalon-MM register bus.
package usb_ctl_pkg;

    // Avalon-MM byte offsets of the software registers.
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_PACKET     = 8'h08;
    localparam logic [7:0] REG_INT_COUNT  = 8'h0c;
    localparam logic [7:0] REG_NAK_COUNT  = 8'h10;
    localparam logic [7:0] REG_DESC_COUNT = 8'h14;
    localparam logic [7:0] REG_POLL       = 8'h18;

    // Field positions and reset values.
    localparam int         CTRL_INT_ENABLE_BIT = 0;
    localparam int         STATUS_LOADED_BIT   = 0;
    localparam int         STATUS_BUSY_BIT     = 1;
    localparam logic [0:0] CTRL_RESET          = 1'h1;

    // Interrupt packet layout.
    localparam int         PKT_USED_BITS    = 20;
    localparam int         PKT_FRAME_BIT    = 18;
    localparam int         PKT_GPIO_BITS    = 11;

    // EEPROM image layout, in 32-bit words.
    localparam logic [7:0] EE_DEV_WORDS     = 8'h05;
    localparam logic [7:0] EE_POLL_WORD     = 8'h05;
    localparam logic [7:0] EE_STRING_WORD   = 8'h06;
    localparam logic [7:0] EE_LAST_WORD     = 8'h85;

    // Descriptor layout and fixed values.
    localparam logic [7:0]  DESC_TYPE_DEVICE  = 8'h01;
    localparam logic [7:0]  DESC_TYPE_STRING  = 8'h03;
    localparam logic [7:0]  DEV_LENGTH        = 8'h12;
    localparam logic [15:0] DEV_BYTES         = 16'h0012;
    localparam logic [15:0] DEF_BCD_USB       = 16'h0200;
    localparam logic [7:0]  DEF_MAX_PACKET    = 8'h40;
    localparam logic [7:0]  DEF_STRING_INDEX  = 8'h00;
    localparam logic [7:0]  DEF_NUM_CONFIGS   = 8'h01;
    localparam logic [7:0]  DEF_RELEASE_LOW   = 8'h00;
    localparam logic [7:0]  DEF_CLASS         = 8'hff;
    localparam logic [7:0]  DEF_SUBCLASS      = 8'h00;
    localparam logic [7:0]  DEF_PROTOCOL      = 8'hff;
    localparam logic [7:0]  STRING_LAST_INDEX = 8'h05;
    localparam logic [15:0] STRING_MAX_BYTES  = 16'h0040;
    localparam logic [7:0]  STAT_LAST         = 8'h02;
    localparam logic [15:0] STAT_BYTES        = 16'h0004;
    localparam logic [7:0]  DEF_POLL_INTERVAL = 8'h04;

    typedef enum logic [1:0] {KIND_DEVICE, KIND_STRING, KIND_STAT} kind_t;
    typedef enum {ST_IDLE, ST_SEND} resp_state_t;
    typedef enum {LD_REQ, LD_DONE} load_state_t;

endpackage
